//--- rtl/acs_pkg.sv
package acs_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;  // mode, preference, rate
   localparam logic [7:0] ADDR_STAT = 8'h04;  // in-use source, mismatch, refusal
   localparam logic [7:0] ADDR_LOCK = 8'h08;  // per-input lock and sync
   localparam logic [7:0] ADDR_IRQS = 8'h0C;  // sticky events, clear on read
   localparam logic [7:0] ADDR_IMSK = 8'h10;  // event mask
   localparam logic [7:0] ADDR_RATE = 8'h14;  // measured rate codes
   localparam logic [7:0] ADDR_NREQ = 8'h18;  // network rate request
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_MODE_BIT = 0;   // 1 = follow external reference
   localparam int CTRL_LEAD_BIT = 1;   // announce as favored network master
   localparam int CTRL_PREF_LSB = 4;   // favored input index, 2 bits
   localparam int CTRL_RATE_LSB = 8;   // configured rate code, 4 bits
   localparam int STAT_CUR_LSB = 0;    // in-use source, 3 bits
   localparam int STAT_MIS_BIT = 4;    // rate mismatch
   localparam int STAT_REF_BIT = 5;    // last rate request refused
   localparam int STAT_MST_BIT = 6;    // network master elected
   localparam int STAT_INT_BIT = 7;    // running on internal clock
   localparam int LOCK_SYNC_LSB = 8;   // sync bits above lock bits
   localparam int IRQ_SRC_BIT = 0;     // in-use source changed
   localparam int IRQ_MIS_BIT = 1;     // mismatch raised
   localparam int IRQ_REF_BIT = 2;     // rate request refused
   localparam int IRQ_LCK_BIT = 3;     // any lock lost
   localparam int IRQ_W = 4;
   // ------------------------------------------------------------
   // reset values and codes
   // ------------------------------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [3:0] RATE_44K1 = 4'h1;  // 44.1 kHz code
   localparam logic [3:0] RATE_48K = 4'h2;   // 48 kHz code
   localparam logic [2:0] SRC_INT = 3'h4;    // internal master code
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 100;         // pclk period
   localparam int LOCK_WIN_NS = 3200;   // longest gap between ref edges
   localparam int LOCK_WIN_CYC = (LOCK_WIN_NS / CLK_NS) < 1 ? 1 : LOCK_WIN_NS / CLK_NS;
   localparam int SW_GAP_CYC = 4;       // mute countdown start: 5 mute cycles before a switch
endpackage

//--- rtl/acs_ref_mon.sv
`timescale 1ns/1ps
// per-input validity monitor: synchronises one reference clock and
// declares lock while edges keep arriving inside the window
module acs_ref_mon #(
   parameter int WIN = acs_pkg::LOCK_WIN_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic ref_clk,
   output logic locked,
   output logic edge_seen
);
   import acs_pkg::*;
   logic s1, s2, s3;                   // synchroniser and edge history
   logic [$clog2(WIN+1)-1:0] gap;      // cycles since last rising edge
   wire rise = s2 & ~s3;               // rising edge, synced side only
   // ------------------------------------------------------------
   // synchroniser and watchdog
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         gap <= '0;
         locked <= 1'b0;
         edge_seen <= 1'b0;
      end else if (ce) begin
         s1 <= ref_clk;
         s2 <= s1;
         s3 <= s2;
         edge_seen <= rise;
         if (rise) begin
            gap <= '0;
            locked <= 1'b1;
         end else if (gap == WIN[$bits(gap)-1:0]) begin
            locked <= 1'b0;     // silence too long: no lock
         end else begin
            gap <= gap + 1'b1;
         end
      end
   end
endmodule

//--- rtl/acs_top.sv
`timescale 1ns/1ps
//
// Behaviour
// R1: use favored input whenever it is valid
// R2: otherwise scan inputs in order, take first valid
// R3: none valid: run from internal master clock
// R4: report lock per reference input
// R5: report sync when valid and synchronous
// R6: flag mismatch against configured rate
// R7: follower refuses conflicting host rate requests
// R8: master election only among equal rates
// R9: network rate change needs explicit reconfiguration
// R10: show reference actually in use
// R11: return to favored input automatically
// R12: glitch-free switching of derived clock
module acs_top #(
   parameter int NIN = 4,   // word, serial links, two-channel, sync header
   parameter int DIV = 4    // internal master divider half period
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NIN-1:0] ref_clk,
   input wire logic [NIN*4-1:0] ref_rate,
   input wire logic net_rate_eq,
   input wire logic net_peer_lead,
   output logic sample_clk,
   output logic net_master,
   output logic irq
);
   import acs_pkg::*;
   initial begin
      if (NIN != 4) $error("acs_top serves exactly four inputs");
      if (DIV < 1) $error("acs_top divider must be at least one");
   end
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0] ctrl;                 // software configuration
   logic [NIN-1:0] lock;              // per-input lock
   logic [NIN-1:0] edges;             // per-input edge pulses
   logic [NIN-1:0] sync_st;           // per-input sync
   logic [NIN-1:0] lock_q;            // lock one cycle earlier
   logic [2:0] cur;                   // source in use
   logic [2:0] tgt_q;                 // pending target
   logic [2:0] gap_cnt;               // mute countdown
   logic mism, refused;
   logic [IRQ_W-1:0] irqs, imsk;
   logic [3:0] net_rate;              // rate applied to network side
   logic [7:0] div_cnt;
   logic int_clk;
   typedef enum {SW_RUN, SW_MUTE} acs_sw_t;
   acs_sw_t sw;
   // ------------------------------------------------------------
   // per-input monitors
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_mon
         acs_ref_mon #(.WIN(LOCK_WIN_CYC)) u_mon (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .ref_clk(ref_clk[gi]),
            .locked(lock[gi]),
            .edge_seen(edges[gi])
         );
      end
   endgenerate
   // ------------------------------------------------------------
   // source selection, combinational
   // ------------------------------------------------------------
   wire follow = ctrl[CTRL_MODE_BIT];
   wire [1:0] pref = ctrl[CTRL_PREF_LSB +: 2];
   wire [3:0] cfg_rate = ctrl[CTRL_RATE_LSB +: 4];
   wire [1:0] p1 = pref + 2'd1;
   wire [1:0] p2 = pref + 2'd2;
   wire [1:0] p3 = pref + 2'd3;
   // favored first, then the rest counting up from it with wrap, else internal
   wire [2:0] pick = lock[pref] ? {1'b0, pref} :                 // R1 R11
                     lock[p1] ? {1'b0, p1} :                      // R2
                     lock[p2] ? {1'b0, p2} :
                     lock[p3] ? {1'b0, p3} : SRC_INT;             // R3
   wire [2:0] want = follow ? pick : SRC_INT;
   wire cur_ext = ~cur[2];
   wire [3:0] cur_rate = ref_rate[cur[1:0]*4 +: 4];
   // rate on the in-use external input governs in follower mode
   wire next_mism = ~follow & (pick != SRC_INT) &                 // R6
                    (ref_rate[pick[1:0]*4 +: 4] != cfg_rate);
   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire hit_ctrl = paddr == ADDR_CTRL;
   wire hit_irqs = paddr == ADDR_IRQS;
   wire hit_imsk = paddr == ADDR_IMSK;
   wire hit_nreq = paddr == ADDR_NREQ;
   wire mapped = hit_ctrl | hit_irqs | hit_imsk | hit_nreq | (paddr == ADDR_STAT) |
                 (paddr == ADDR_LOCK) | (paddr == ADDR_RATE);
   // a follower on an external input keeps its rate unless the same write returns to internal
   wire req_rate_bad = follow & pwdata[CTRL_MODE_BIT] &           // R7
                       cur_ext & (pwdata[CTRL_RATE_LSB +: 4] != cur_rate);
   wire [31:0] ctrl_w = req_rate_bad ?
                        {pwdata[31:12], cfg_rate, pwdata[7:0]} : pwdata;
   wire [31:0] stat_v = {24'h0, ~cur_ext, net_master, refused, mism, 1'b0, cur};
   logic [31:0] rmux;
   always_comb begin
      case (paddr)
         ADDR_CTRL: rmux = ctrl;
         ADDR_STAT: rmux = stat_v;                                   // R10
         ADDR_LOCK: rmux = {20'h0, sync_st, 4'h0, lock};             // R4 R5
         ADDR_IRQS: rmux = {28'h0, irqs};
         ADDR_IMSK: rmux = {28'h0, imsk};
         ADDR_RATE: rmux = {16'h0, ref_rate};
         ADDR_NREQ: rmux = {28'h0, net_rate};
         default: rmux = 32'h0;
      endcase
   end
   wire [IRQ_W-1:0] ev;
   assign ev[IRQ_SRC_BIT] = (sw == SW_MUTE) && (gap_cnt == 3'd0);
   assign ev[IRQ_MIS_BIT] = next_mism & ~mism;
   assign ev[IRQ_REF_BIT] = wr & hit_ctrl & req_rate_bad;
   assign ev[IRQ_LCK_BIT] = |(lock_q & ~lock);
   // a read clears only the bits it returned: an event landing during
   // the transfer survives to the next read
   wire [IRQ_W-1:0] irq_clr = (rd & hit_irqs) ? prdata[IRQ_W-1:0] : '0;
   // ------------------------------------------------------------
   // bus slave, no wait states
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (ce) begin
         // ready answers in the cycle after setup
         pready <= psel & ~pready;
         pslverr <= psel & ~pready & ~mapped;
         // capture in setup only, so the word stands through the access
         if (psel & ~penable & ~pwrite) begin
            prdata <= rmux;
         end
      end
   end
   // ------------------------------------------------------------
   // registers and events
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RST;
         imsk <= '0;
         irqs <= '0;
         refused <= 1'b0;
         net_rate <= 4'h0;
         mism <= 1'b0;
         lock_q <= '0;
      end else if (ce) begin
         lock_q <= lock;
         mism <= next_mism;
         if (wr & hit_ctrl) begin
            ctrl <= ctrl_w;
            refused <= req_rate_bad;                               // R7
         end
         if (wr & hit_imsk) imsk <= pwdata[IRQ_W-1:0];
         // network rate changes only on an explicit write
         if (wr & hit_nreq) net_rate <= pwdata[3:0];               // R9
         // set wins over read clear
         irqs <= (irqs & ~irq_clr) | ev;
      end
   end
   // ------------------------------------------------------------
   // sync status: lock on an input with same rate as the clock in use
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_st <= '0;
      end else if (ce) begin
         for (int i = 0; i < NIN; i++) begin
            sync_st[i] <= lock[i] &                                // R5
               (ref_rate[i*4 +: 4] == (cur_ext ? cur_rate : cfg_rate));
         end
      end
   end
   // ------------------------------------------------------------
   // glitch-free switch: mute low, change source, resume
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw <= SW_RUN;
         cur <= SRC_INT;
         tgt_q <= SRC_INT;
         gap_cnt <= 3'd0;
         sample_clk <= 1'b0;
      end else if (ce) begin
         case (sw)
            SW_RUN: begin
               // leave only after the output is low, so no runt pulse
               if (want != cur && !sample_clk) begin                // R12
                  sw <= SW_MUTE;
                  tgt_q <= want;
                  gap_cnt <= 3'(SW_GAP_CYC);
                  sample_clk <= 1'b0;                               // R12
               end else begin
                  sample_clk <= cur_ext ? lock[cur[1:0]] & ref_clk_s(cur) : int_clk;
               end
            end
            SW_MUTE: begin
               sample_clk <= 1'b0;
               if (gap_cnt == 3'd0) begin
                  cur <= tgt_q;                                     // R10 R11
                  sw <= SW_RUN;
               end else begin
                  gap_cnt <= gap_cnt - 3'd1;
               end
            end
            default: sw <= SW_RUN;
         endcase
      end
   end
   // one-cycle edge pulse of the input in use, from its monitor
   function automatic logic ref_clk_s(input logic [2:0] s);
      ref_clk_s = edges[s[1:0]];
   endfunction
   // ------------------------------------------------------------
   // internal master divider, election, interrupt
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 8'h0;
         int_clk <= 1'b0;
         net_master <= 1'b0;
         irq <= 1'b0;
      end else if (ce) begin
         if (div_cnt == 8'(DIV - 1)) begin
            div_cnt <= 8'h0;
            int_clk <= ~int_clk;
         end else begin
            div_cnt <= div_cnt + 8'h1;
         end
         // master only among equal rates, and no rival favored master
         net_master <= ctrl[CTRL_LEAD_BIT] & net_rate_eq & ~net_peer_lead;  // R8
         irq <= |(irqs & imsk);
      end
   end
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sel_fav_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
      (ce && sw == SW_RUN && follow && lock[pref] && cur != {1'b0, pref}) |->
      ##[1:16] (cur == {1'b0, pref}) || !lock[pref] || !ce || !follow)
      else $error("favored input not adopted");
   sel_int_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (ce && lock == '0 && follow) [*8] |-> ##[0:8] (cur == SRC_INT || !ce))
      else $error("internal clock not taken");
   mute_low_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (sw == SW_MUTE) |-> !sample_clk)
      else $error("clock active while switching");
   mism_raise_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
      ce && next_mism |=> mism || !ce)
      else $error("mismatch not raised");
   rate_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
      ce && wr && hit_ctrl && req_rate_bad |=> ctrl[CTRL_RATE_LSB +: 4] == $past(cfg_rate))
      else $error("conflicting rate accepted");
   elect_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
      $past(ce) && net_master |-> $past(ctrl[CTRL_LEAD_BIT]) && $past(net_rate_eq) &&
         !$past(net_peer_lead))
      else $error("master elected illegally");
   net_rate_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
      ce && !(wr && hit_nreq) |=> $stable(net_rate))
      else $error("network rate changed unasked");
   sync_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
      ce && (sync_st & ~$past(lock)) != '0 |-> 1'b0)
      else $error("sync without lock");
   irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && (irqs & imsk) != '0 |=> irq || !ce)
      else $error("interrupt not raised");
endmodule

//--- testbench/acs_ref_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far-side reference sources
// ------------------------------------------------------------
// one clock per input, all from one free phase; an input that is off
// parks its clock low, so no stale edges can fake a lock
module acs_ref_src #(
   parameter int HALF_NS = 400
) (
   input wire logic [3:0] en,
   input wire logic [15:0] rate_in,
   output logic [3:0] ref_clk,
   output logic [15:0] ref_rate
);
   logic run; // shared phase, unrelated to pclk
   // offset start so edges never line up with pclk
   initial begin
      run = 1'b0;
      #37;
      forever begin
         #HALF_NS run = ~run;
      end
   end
   // gated clocks stand still while a source is off
   assign ref_clk = en & {4{run}};
   // a silent source reports no rate code at all
   for (genvar g = 0; g < 4; g++) begin : g_rate
      assign ref_rate[g*4 +: 4] = en[g] ? rate_in[g*4 +: 4] : 4'h0;
   end
endmodule

//--- testbench/acs_top_tb.sv
`timescale 1ns/1ps
module acs_top_tb;
   import acs_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite;
   logic ce; // held high except while one test freezes the logic
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd; // rd: data of last access
   logic pready, pslverr, err, sample_clk, net_master, irq;
   logic net_rate_eq, net_peer_lead;
   logic [3:0] src_en, ref_clk; // which sources run
   logic [15:0] rate_in, ref_rate;
   int fail_count, compares;
   // ------------------------------------------------------------
   // parts
   // ------------------------------------------------------------
   acs_top acs_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clk(ref_clk),
      .ref_rate(ref_rate), .net_rate_eq(net_rate_eq),
      .net_peer_lead(net_peer_lead), .sample_clk(sample_clk),
      .net_master(net_master), .irq(irq));
   acs_ref_src acs_ref_src_i (.en(src_en), .rate_in(rate_in),
      .ref_clk(ref_clk), .ref_rate(ref_rate));
   // 10 MHz bus clock
   initial begin
      pclk = 1'b0;
      forever begin
         #50 pclk = ~pclk;
      end
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // control word from its fields
   function automatic logic [31:0] ctrl_w(logic f, logic l, logic [1:0] p,
         logic [3:0] r);
      ctrl_w = 32'h0;
      ctrl_w[CTRL_MODE_BIT] = f;
      ctrl_w[CTRL_LEAD_BIT] = l;
      ctrl_w[CTRL_PREF_LSB +: 2] = p;
      ctrl_w[CTRL_RATE_LSB +: 4] = r;
   endfunction
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   // count rising edges of the derived clock over 80 cycles
   task automatic chk_clk(input int exp);
      int c;
      logic p;
      c = 0;
      p = sample_clk;
      repeat (80) begin
         @(posedge pclk);
         if (sample_clk === 1'b1 && p === 1'b0) begin
            c++;
         end
         p = sample_clk;
      end
      chk_word(c, exp);
   endtask
   // one apb transfer; an idle edge after it keeps psel from being
   // lowered and raised in one time step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 50) begin
         fail_count++;
         $display("Error at %0t: no ready", $time);
         tally_and_finish();
      end
   endtask
   // poll a field until it settles, bounded, then compare
   task automatic expect_reg(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      int k;
      k = 0;
      do begin
         apb(1'b0, a, 32'h0);
         k++;
      end while ((rd & m) !== e && k < 100);
      chk_word(rd & m, e);
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      fail_count = 0;
      compares = 0;
      presetn = 1'b0;
      ce = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {net_rate_eq, net_peer_lead} = 2'b00;
      src_en = 4'h0;
      rate_in = 16'h2222; // all sources at 48 kHz
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // after reset: internal clock, control cleared
      expect_reg(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RST);
      expect_reg(ADDR_STAT, 32'h87, 32'h84);
      // internal master, divider of four: period 8 cycles
      chk_clk(10);
      $display("test reset done");
      // favored input 2 in follower mode
      src_en <= 4'hF;
      apb(1'b1, ADDR_CTRL, ctrl_w(1'b1, 1'b0, 2'd2, RATE_48K));
      expect_reg(ADDR_LOCK, 32'hF, 32'hF);
      expect_reg(ADDR_STAT, 32'h87, 32'h2);
      expect_reg(ADDR_LOCK, 32'h400, 32'h400);
      // one pulse per 800 ns reference period: 10 in 80 cycles
      chk_clk(10);
      // frozen by the clock enable: no pulse at all
      ce <= 1'b0;
      @(posedge pclk);
      chk_clk(0);
      ce <= 1'b1;
      apb(1'b0, ADDR_IRQS, 32'h0);
      apb(1'b1, ADDR_IMSK, 32'h0);
      $display("test favored done");
      // favored and next in line lost: scan skips on to input 0,
      // events held while masked
      src_en <= 4'h3;
      expect_reg(ADDR_STAT, 32'h87, 32'h0);
      chk_bit(irq, 1'b0);
      apb(1'b1, ADDR_IMSK, 32'hF);
      repeat (2) @(posedge pclk);
      chk_bit(irq, 1'b1);
      apb(1'b0, ADDR_IRQS, 32'h0);
      chk_word(rd & 32'h9, 32'h9);
      apb(1'b0, ADDR_IRQS, 32'h0);
      chk_word(rd, 32'h0);
      repeat (2) @(posedge pclk);
      chk_bit(irq, 1'b0);
      $display("test fallback done");
      // favored back without host help, then all sources gone
      src_en <= 4'hF;
      expect_reg(ADDR_STAT, 32'h87, 32'h2);
      src_en <= 4'h0;
      expect_reg(ADDR_STAT, 32'h87, 32'h84);
      expect_reg(ADDR_LOCK, 32'hF, 32'h0);
      $display("test return done");
      // follower refuses a conflicting rate
      src_en <= 4'hF;
      apb(1'b1, ADDR_CTRL, ctrl_w(1'b1, 1'b0, 2'd0, RATE_48K));
      expect_reg(ADDR_STAT, 32'h87, 32'h0);
      apb(1'b0, ADDR_IRQS, 32'h0);
      apb(1'b1, ADDR_CTRL, ctrl_w(1'b1, 1'b0, 2'd0, RATE_44K1));
      expect_reg(ADDR_CTRL, 32'hF01, ctrl_w(1'b1, 1'b0, 2'd0, RATE_48K));
      expect_reg(ADDR_STAT, 32'h20, 32'h20);
      apb(1'b0, ADDR_IRQS, 32'h0);
      chk_word(rd & 32'h4, 32'h4);
      // leaving follower mode lets the same rate through
      apb(1'b1, ADDR_CTRL, ctrl_w(1'b0, 1'b0, 2'd0, RATE_44K1));
      expect_reg(ADDR_CTRL, 32'hF01, ctrl_w(1'b0, 1'b0, 2'd0, RATE_44K1));
      expect_reg(ADDR_STAT, 32'h87, 32'h84);
      $display("test refusal done");
      // host rate 44.1 kHz against 48 kHz sources
      expect_reg(ADDR_STAT, 32'h10, 32'h10);
      apb(1'b0, ADDR_IRQS, 32'h0);
      chk_word(rd & 32'h2, 32'h2);
      apb(1'b1, ADDR_CTRL, ctrl_w(1'b0, 1'b1, 2'd0, RATE_48K));
      expect_reg(ADDR_STAT, 32'h10, 32'h0);
      $display("test mismatch done");
      // election: only equal rates, lost to another favored master
      for (int i = 0; i < 4; i++) begin
         {net_rate_eq, net_peer_lead} <= i[1:0];
         @(posedge pclk);
         expect_reg(ADDR_STAT, 32'h40, {25'h0, i == 2, 6'h0});
         chk_bit(net_master, i == 2);
      end
      $display("test election done");
      // network rate holds until written again
      apb(1'b1, ADDR_NREQ, 32'h1);
      expect_reg(ADDR_NREQ, 32'hF, 32'h1);
      rate_in <= 16'h1111;
      repeat (40) @(posedge pclk);
      expect_reg(ADDR_NREQ, 32'hF, 32'h1);
      $display("test network rate done");
      // unmapped place: error, zero data
      apb(1'b0, 8'h1C, 32'h0);
      chk_bit(err, 1'b1);
      chk_word(rd, 32'h0);
      $display("test unmapped done");
      tally_and_finish();
   end
endmodule
